//--- flp_flag_ctrl.sv
// flash led driver protection, mode and fault flag logic with its registers
// assumes register accesses arrive decoded from the serial bus engine as
// one-cycle strobes, and that flash pulse timing lives outside this block
`include "flp_map.svh"
`default_nettype none

module flp_flag_ctrl
    import flp_pkg::*;
(
    // clock, reset, hardware enable
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic hardware_enable_pin,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // fields of the brightness and configuration registers outside
    input wire logic voltage_mode_bit,
    input wire logic mode_enable_hi,
    input wire logic mode_enable_lo,
    input wire logic [1:0] indicator_level,
    input wire logic thermistor_mode_sel,
    input wire logic tx_a_transmit_mode,
    input wire logic tx_b_transmit_mode,
    input wire logic tx_b_active_high,
    // flash sequencer
    input wire logic flash_pulse_active,
    input wire logic flash_trigger,
    input wire logic flash_timeout_expired,
    // transmit pins
    input wire logic transmit_a_input,
    input wire logic transmit_b_input,
    // asynchronous comparator levels
    input wire logic thermistor_trip_raw,
    input wire logic undervoltage_raw,
    input wire logic vin_recovered_raw,
    input wire logic overtemp_raw,
    input wire logic overvoltage_detect,
    input wire logic led_short_raw,
    // led and pin control
    output flp_drive_e led_drive,
    output logic boost_enable,
    output logic indicator_output,
    output logic [1:0] indicator_level_sel,
    output logic thermistor_sense_en,
    output logic voltage_output_en,
    output logic vin_monitor_en,
    output logic [1:0] undervoltage_threshold,
    output logic enable_bits_clear,
    output logic timeout_suppress
);

    ////////////////////////////////////////////////////////////////////////////
    // synchronised comparators and qualifiers

    logic [5:0] cmp_s;
    logic trip_s, uv_s, vin_ok_s, ovt_s, ovp_s, short_s;
    logic trip_q, open_q, short_q;

    flp_sync #(.W(6)) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in({led_short_raw, overvoltage_detect, overtemp_raw, vin_recovered_raw,
            undervoltage_raw, thermistor_trip_raw}),
        .sync_out(cmp_s)
    );

    assign {short_s, ovp_s, ovt_s, vin_ok_s, uv_s, trip_s} = cmp_s;

    flp_qual #(.COUNT(`FLP_THERM_CYC)) u_trip_qual (
        .clk_sys(clk_sys),
        .rst(rst),
        .level_in(trip_s & thermistor_mode_sel),
        .qualified(trip_q)
    );

    flp_qual #(.COUNT(`FLP_SHORT_CYC)) u_short_qual (
        .clk_sys(clk_sys),
        .rst(rst),
        .level_in(short_s),
        .qualified(short_q)
    );

    flp_qual #(.COUNT(`FLP_OPEN_CYC)) u_open_qual (
        .clk_sys(clk_sys),
        .rst(rst),
        .level_in(ovp_s),
        .qualified(open_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // register decode and storage

    logic hw_off;
    logic sel_vin, sel_flags, sel_cfg;
    logic rd_flags;
    logic [7:0] vin_mon_q, prot_cfg_q, flags_q, flags_d, flag_set;
    logic [7:0] rdata_q, rdata_d;

    assign hw_off = !hardware_enable_pin;
    assign sel_vin = (reg_addr == `FLP_ADDR_VIN_MON);
    assign sel_flags = (reg_addr == `FLP_ADDR_FLAGS);
    assign sel_cfg = (reg_addr == `FLP_ADDR_PROT_CFG);
    assign rd_flags = reg_rd_en & sel_flags;
    assign rdata_d = sel_vin ? vin_mon_q : sel_flags ? (flags_q & `FLP_FLAGS_MASK) :
        sel_cfg ? prot_cfg_q : 8'h00;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            vin_mon_q <= `FLP_VIN_MON_RST;
            prot_cfg_q <= `FLP_PROT_CFG_RST;
            flags_q <= `FLP_FLAGS_RST;
            rdata_q <= 8'h00;
        end else if (hw_off) begin
            vin_mon_q <= `FLP_VIN_MON_RST;
            prot_cfg_q <= `FLP_PROT_CFG_RST;
            flags_q <= 8'h00;
            rdata_q <= 8'h00;
        end else begin
            if (reg_wr_en && sel_vin)
                vin_mon_q <= reg_wdata;
            if (reg_wr_en && sel_cfg)
                prot_cfg_q <= reg_wdata;
            flags_q <= flags_d;
            if (reg_rd_en)
                rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // mode decode and event detection

    logic [1:0] mode_en;
    logic led_active, torch_req, mon_en;
    logic therm_act_off, uv_act_off, txb_act_off, alt_torch;
    logic tx_a_q, tx_b_q, trig_q, pulse_q, ovt_q;
    logic tx_a_rise, tx_b_event, txb_asserted, trig_rise, pulse_start, to_hit;

    assign mode_en = {mode_enable_hi, mode_enable_lo};
    assign torch_req = (mode_en == `FLP_MODE_TORCH);
    assign led_active = (led_drive != DRIVE_OFF);
    assign mon_en = vin_mon_q[`FLP_VIN_EN];
    assign therm_act_off = prot_cfg_q[`FLP_CFG_THERM_ACT];
    assign uv_act_off = prot_cfg_q[`FLP_CFG_UV_ACT];
    assign txb_act_off = prot_cfg_q[`FLP_CFG_TXB_OFF];
    assign alt_torch = prot_cfg_q[`FLP_CFG_ALT_TORCH];
    assign tx_a_rise = transmit_a_input & !tx_a_q;
    assign txb_asserted = (transmit_b_input == tx_b_active_high);
    assign tx_b_event = (transmit_b_input != tx_b_q) & txb_asserted;
    assign trig_rise = flash_trigger & !trig_q;
    assign pulse_start = flash_pulse_active & !pulse_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_a_q <= 1'b0;
            tx_b_q <= 1'b0;
            trig_q <= 1'b0;
            pulse_q <= 1'b0;
            ovt_q <= 1'b0;
        end else begin
            tx_a_q <= transmit_a_input;
            tx_b_q <= transmit_b_input;
            trig_q <= flash_trigger;
            pulse_q <= flash_pulse_active;
            ovt_q <= ovt_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // protection holds: set by the fault, released by a read plus recovery

    logic aet_q, aet_d;
    logic ntc_hold_q, ntc_hold_d, ntc_ack_q, ntc_ack_d;
    logic uv_hold_q, uv_hold_d, uv_ack_q, uv_ack_d;
    logic ntc_set, uv_set;

    assign ntc_set = trip_q & led_active;
    assign uv_set = mon_en & uv_s & led_active;
    assign ntc_ack_d = ntc_hold_q & (ntc_ack_q | rd_flags) & !ntc_set;
    assign ntc_hold_d = ntc_set | (ntc_hold_q & !(ntc_ack_q & !trip_s));
    assign uv_ack_d = uv_hold_q & (uv_ack_q | rd_flags) & !uv_set;
    assign uv_hold_d = uv_set | (uv_hold_q & !(uv_ack_q & vin_ok_s));
    // transmit a high before the trigger: untimed torch until it drops
    assign aet_d = alt_torch & tx_a_transmit_mode & transmit_a_input &
        ((trig_rise & tx_a_q) | aet_q);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            aet_q <= 1'b0;
            ntc_hold_q <= 1'b0;
            ntc_ack_q <= 1'b0;
            uv_hold_q <= 1'b0;
            uv_ack_q <= 1'b0;
        end else if (hw_off) begin
            aet_q <= 1'b0;
            ntc_hold_q <= 1'b0;
            ntc_ack_q <= 1'b0;
            uv_hold_q <= 1'b0;
            uv_ack_q <= 1'b0;
        end else begin
            aet_q <= aet_d;
            ntc_hold_q <= ntc_hold_d;
            ntc_ack_q <= ntc_ack_d;
            uv_hold_q <= uv_hold_d;
            uv_ack_q <= uv_ack_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // led drive level

    logic cut_off, reduce;
    flp_drive_e drive_q, drive_d;

    assign cut_off = ovt_s | (ntc_hold_q & therm_act_off) | (uv_hold_q & uv_act_off) |
        (tx_b_transmit_mode & txb_asserted & txb_act_off & flash_pulse_active);
    // transmit a reduces only while a timed flash runs
    assign reduce = ntc_hold_q | uv_hold_q | (tx_a_transmit_mode & transmit_a_input) |
        (tx_b_transmit_mode & txb_asserted);
    assign drive_d = cut_off ? DRIVE_OFF :
        aet_q ? DRIVE_TORCH :
        flash_pulse_active ? (reduce ? DRIVE_TORCH : DRIVE_FLASH) :
        torch_req ? DRIVE_TORCH : DRIVE_OFF;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            drive_q <= DRIVE_OFF;
        else if (hw_off)
            drive_q <= DRIVE_OFF;
        else
            drive_q <= drive_d;
    end

    assign led_drive = drive_q;

    ////////////////////////////////////////////////////////////////////////////
    // flag sets

    assign to_hit = flash_timeout_expired & flash_pulse_active & !aet_q;
    always_comb begin
        flag_set = 8'h00;
        flag_set[`FLP_FLAG_TIMEOUT] = to_hit;
        flag_set[`FLP_FLAG_OVERTEMP] = ovt_s & !ovt_q;
        flag_set[`FLP_FLAG_LED_FAIL] = led_active & (open_q | short_q);
        flag_set[`FLP_FLAG_TX_A] = tx_a_transmit_mode & tx_a_rise;
        flag_set[`FLP_FLAG_TX_B] = tx_b_transmit_mode & tx_b_event;
        flag_set[`FLP_FLAG_THERM] = ntc_set;
        flag_set[`FLP_FLAG_VIN] = mon_en & uv_s;
    end

    // next flash clears the timeout flag; a simultaneous expiry still sets it
    logic [7:0] flags_after;
    assign flags_after = flags_q & ~(8'(pulse_start) << `FLP_FLAG_TIMEOUT);
    // set wins over both clears
    assign flags_d = ((flags_after & ~{8{rd_flags}}) | flag_set) & `FLP_FLAGS_MASK;

    ////////////////////////////////////////////////////////////////////////////
    // pin and mode outputs

    logic ind_q, therm_en_q, vout_q, boost_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ind_q <= 1'b0;
            therm_en_q <= 1'b0;
            vout_q <= 1'b0;
            boost_q <= 1'b0;
        end else begin
            ind_q <= !thermistor_mode_sel & (mode_en == `FLP_MODE_IND) & !ovt_s
                & hardware_enable_pin;
            therm_en_q <= thermistor_mode_sel;
            vout_q <= voltage_mode_bit & !ovt_s & hardware_enable_pin;
            boost_q <= !ovt_s & hardware_enable_pin;
        end
    end

    assign indicator_output = ind_q;
    assign indicator_level_sel = indicator_level;
    assign thermistor_sense_en = therm_en_q;
    assign voltage_output_en = vout_q;
    assign boost_enable = boost_q;
    assign vin_monitor_en = mon_en;
    assign undervoltage_threshold = vin_mon_q[`FLP_VIN_THR_HI:`FLP_VIN_THR_LO];
    assign enable_bits_clear = to_hit;
    assign timeout_suppress = aet_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    ind_mode_a:
    assert property (@(posedge clk_sys) disable iff (rst) (!thermistor_mode_sel && mode_en ==
        `FLP_MODE_IND && !ovt_s && hardware_enable_pin) |=> indicator_output)
        else $error("indicator not driven in indicator mode");
    therm_pin_a:
    assert property (@(posedge clk_sys) disable iff (rst) thermistor_mode_sel |=> !indicator_output)
        else $error("indicator driven in thermistor mode");
    trip_off_a:
    assert property (@(posedge clk_sys) disable iff (rst || hw_off)
        (ntc_hold_q && therm_act_off && hardware_enable_pin) |=> led_drive == DRIVE_OFF)
        else $error("thermistor shutdown not applied");
    trip_deglitch_a:
    assert property (@(posedge clk_sys) disable iff (rst) $rose(trip_q) |-> $past(trip_s, 2))
        else $error("trip acted without persistence");
    trip_release_a:
    assert property (@(posedge clk_sys) disable iff (rst || hw_off)
        $fell(ntc_hold_q) |-> $past(ntc_ack_q) && !$past(trip_s))
        else $error("trip released without read and recovery");
    uv_release_a:
    assert property (@(posedge clk_sys) disable iff (rst || hw_off)
        $fell(uv_hold_q) |-> $past(uv_ack_q) && $past(vin_ok_s))
        else $error("undervoltage released early");
    tx_flag_a:
    assert property (@(posedge clk_sys) disable iff (rst || hw_off)
        (tx_a_transmit_mode && tx_a_rise) |=> flags_q[`FLP_FLAG_TX_A])
        else $error("transmit a flag lost");
    ovt_stop_a:
    assert property (@(posedge clk_sys) disable iff (rst) ovt_s |=> !boost_enable &&
        led_drive == DRIVE_OFF && !indicator_output)
        else $error("overtemperature did not stop outputs");
    timeout_flag_a:
    assert property (@(posedge clk_sys) disable iff (rst || hw_off) to_hit |=>
        flags_q[`FLP_FLAG_TIMEOUT] && $past(enable_bits_clear))
        else $error("timeout flag not set");
    fail_clear_a:
    assert property (@(posedge clk_sys) disable iff (rst) $fell(flags_q[`FLP_FLAG_LED_FAIL])
        |-> $past(rd_flags) || $past(hw_off))
        else $error("led fail flag cleared without cause");
    aet_torch_a:
    assert property (@(posedge clk_sys) disable iff (rst || hw_off) (aet_q && !cut_off)
        |=> led_drive == DRIVE_TORCH)
        else $error("alternative torch not driven");

endmodule // flp_flag_ctrl

`default_nettype wire

//--- flp_flag_ctrl_bench.sv
// self-checking bench of the flash protection flag block
// assumes a 10 MHz clock and the host model on the register port
`default_nettype none
`include "flp_map.svh"

module flp_flag_ctrl_bench
    import flp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] FA = `FLP_ADDR_FLAGS;
    localparam logic [7:0] VA = `FLP_ADDR_VIN_MON;
    localparam logic [7:0] CA = `FLP_ADDR_PROT_CFG;
    logic clk_sys, rst, hardware_enable_pin, voltage_mode_bit, mode_enable_hi, mode_enable_lo;
    logic thermistor_mode_sel, tx_a_transmit_mode, tx_b_transmit_mode, tx_b_active_high;
    logic flash_pulse_active, flash_trigger, flash_timeout_expired;
    logic transmit_a_input, transmit_b_input, thermistor_trip_raw, undervoltage_raw;
    logic vin_recovered_raw, overtemp_raw, overvoltage_detect, led_short_raw;
    logic [1:0] indicator_level, indicator_level_sel, undervoltage_threshold;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_wr_en, reg_rd_en, boost_enable, indicator_output, thermistor_sense_en;
    logic voltage_output_en, vin_monitor_en, enable_bits_clear, timeout_suppress, rd_seen;
    flp_drive_e led_drive;
    logic [7:0] exp_q[$];
    logic [31:0] rnd;
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;

    flp_host_model flp_host_model_inst (.clk_sys, .reg_addr, .reg_wr_en, .reg_rd_en,
        .reg_wdata);

    flp_flag_ctrl flp_flag_ctrl_inst (.clk_sys, .rst, .hardware_enable_pin, .reg_addr,
        .reg_wr_en, .reg_rd_en, .reg_wdata, .reg_rdata, .voltage_mode_bit, .mode_enable_hi,
        .mode_enable_lo, .indicator_level, .thermistor_mode_sel, .tx_a_transmit_mode,
        .tx_b_transmit_mode, .tx_b_active_high, .flash_pulse_active, .flash_trigger,
        .flash_timeout_expired, .transmit_a_input, .transmit_b_input, .thermistor_trip_raw,
        .undervoltage_raw, .vin_recovered_raw, .overtemp_raw, .overvoltage_detect,
        .led_short_raw, .led_drive, .boost_enable, .indicator_output, .indicator_level_sel,
        .thermistor_sense_en, .voltage_output_en, .vin_monitor_en, .undervoltage_threshold,
        .enable_bits_clear, .timeout_suppress);

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    task automatic results();
        $display("errors %0d checks %0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ends mid-cycle so outputs are settled when checked
    task automatic cy(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        flp_host_model_inst.access(a, 8'h00, 1'b0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        flp_host_model_inst.access(a, d, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // read data is valid the cycle after the read strobe is taken
    always @(posedge clk_sys) begin
        rd_seen <= reg_rd_en;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            results();
        end
    end

    always @(negedge clk_sys) begin
        if (rd_seen === 1'b1 && exp_q.size() > 0) begin
            chk(reg_rdata, exp_q.pop_front(), "rdata");
        end
    end

    initial begin
        {voltage_mode_bit, mode_enable_hi, mode_enable_lo, thermistor_mode_sel} = 4'h0;
        {tx_a_transmit_mode, tx_b_transmit_mode, tx_b_active_high, flash_trigger} = 4'h0;
        {flash_pulse_active, flash_timeout_expired, transmit_a_input, transmit_b_input} = 4'h0;
        {thermistor_trip_raw, undervoltage_raw, vin_recovered_raw, overtemp_raw} = 4'h0;
        {overvoltage_detect, led_short_raw, indicator_level} = 4'h0;
        rst = 1'b1;
        hardware_enable_pin = 1'b1;
        rnd = 32'he9ed;
        cy(15);
        @(posedge clk_sys);
        rst <= 1'b0;
        rd(FA, `FLP_FLAGS_RST);
        rd(FA, 8'h00);
        rd(VA, `FLP_VIN_MON_RST);
        rd(CA, `FLP_PROT_CFG_RST);
        wr(FA, 8'hFF);
        rd(8'h55, 8'h00);
        rd(FA, 8'h00);
        for (int i = 0; i < 4; i++) begin
            rnd = nx(rnd);
            wr(VA, {5'h1E, i[1:0], rnd[0]});
            rd(VA, {5'h1E, i[1:0], rnd[0]});
            chk(8'(vin_monitor_en), 8'(rnd[0]), "mon en");
            chk(8'(undervoltage_threshold), 8'(i[1:0]), "uv thr");
        end
        wr(VA, `FLP_VIN_MON_RST);
        @(posedge clk_sys);
        mode_enable_lo <= 1'b1;
        indicator_level <= rnd[5:4];
        cy(4);
        chk(8'(indicator_output), 8'h01, "ind on");
        chk(8'(indicator_level_sel), 8'(rnd[5:4]), "ind lvl");
        @(posedge clk_sys);
        thermistor_mode_sel <= 1'b1;
        tx_a_transmit_mode <= 1'b1;
        tx_b_transmit_mode <= 1'b1;
        cy(4);
        chk(8'(indicator_output), 8'h00, "ind off");
        chk(8'(thermistor_sense_en), 8'h01, "sense");
        for (int p = 1; p >= 0; p--) begin
            @(posedge clk_sys);
            tx_b_active_high <= p[0];
            transmit_b_input <= !p[0];
            cy(4);
            flp_host_model_inst.access(FA, 8'h00, 1'b0);
            @(posedge clk_sys);
            transmit_a_input <= p[0];
            transmit_b_input <= p[0];
            cy(4);
            rd(FA, {3'h0, 1'b1, p[0], 3'h0});
        end
        @(posedge clk_sys);
        tx_a_transmit_mode <= 1'b0;
        tx_b_transmit_mode <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_sys);
            overtemp_raw <= 1'b1;
            cy(4);
            chk(8'(boost_enable), 8'h00, "boost off");
            @(posedge clk_sys);
            overtemp_raw <= 1'b0;
            cy(4);
            chk(8'(boost_enable), 8'h01, "boost on");
        end
        rd(FA, 8'h02);
        @(posedge clk_sys);
        flash_pulse_active <= 1'b1;
        flash_timeout_expired <= 1'b1;
        @(negedge clk_sys);
        chk(8'(enable_bits_clear), 8'h01, "en clear");
        @(posedge clk_sys);
        flash_timeout_expired <= 1'b0;
        flash_pulse_active <= 1'b0;
        rd(FA, 8'h01);
        @(posedge clk_sys);
        {flash_pulse_active, flash_timeout_expired} <= 2'h3;
        @(posedge clk_sys);
        {flash_pulse_active, flash_timeout_expired} <= 2'h0;
        @(posedge clk_sys);
        flash_pulse_active <= 1'b1;
        @(posedge clk_sys);
        flash_pulse_active <= 1'b0;
        rd(FA, 8'h00);
        wr(CA, 8'hF4);
        @(posedge clk_sys);
        tx_a_transmit_mode <= 1'b1;
        flash_trigger <= 1'b1;
        @(posedge clk_sys);
        transmit_a_input <= 1'b1;
        cy(3);
        chk(8'(timeout_suppress), 8'h00, "alt late");
        @(posedge clk_sys);
        flash_trigger <= 1'b0;
        @(posedge clk_sys);
        flash_trigger <= 1'b1;
        cy(3);
        chk(8'(timeout_suppress), 8'h01, "alt torch");
        chk(8'(led_drive), 8'(DRIVE_TORCH), "alt drive");
        @(posedge clk_sys);
        {tx_a_transmit_mode, transmit_a_input, flash_trigger} <= 3'h0;
        wr(CA, 8'hF0);
        rd(FA, 8'h08);
        @(posedge clk_sys);
        {mode_enable_hi, mode_enable_lo, thermistor_mode_sel} <= 3'h4;
        overvoltage_detect <= 1'b1;
        cy(30);
        chk(8'(led_drive), 8'(DRIVE_TORCH), "torch");
        @(posedge clk_sys);
        overvoltage_detect <= 1'b0;
        cy(4);
        rd(FA, 8'h04);
        @(posedge clk_sys);
        led_short_raw <= 1'b1;
        cy(1000);
        rd(FA, 8'h00);
        cy(1600);
        rd(FA, 8'h04);
        @(posedge clk_sys);
        hardware_enable_pin <= 1'b0;
        led_short_raw <= 1'b0;
        cy(6);
        @(posedge clk_sys);
        hardware_enable_pin <= 1'b1;
        cy(4);
        rd(FA, 8'h00);
        @(posedge clk_sys);
        {mode_enable_lo, thermistor_mode_sel, flash_pulse_active, voltage_mode_bit} <= 4'hF;
        for (int a = 0; a < 2; a++) begin
            wr(CA, {6'h3C, a[0], 1'b0});
            @(posedge clk_sys);
            thermistor_trip_raw <= 1'b1;
            cy(1000);
            chk(8'(led_drive), 8'(DRIVE_FLASH), "deglitch");
            chk(8'(voltage_output_en), 8'h01, "vout");
            cy(1600);
            chk(8'(led_drive), 8'(a == 1 ? DRIVE_OFF : DRIVE_TORCH), "trip");
            @(posedge clk_sys);
            thermistor_trip_raw <= 1'b0;
            cy(6);
            chk(8'(led_drive), 8'(a == 1 ? DRIVE_OFF : DRIVE_TORCH), "held");
            rd(FA, 8'h20);
            cy(4);
            chk(8'(led_drive), 8'(DRIVE_FLASH), "resume");
        end
        flp_host_model_inst.access(FA, 8'h00, 1'b0);
        wr(VA, 8'hF1);
        @(posedge clk_sys);
        undervoltage_raw <= 1'b1;
        cy(6);
        chk(8'(led_drive), 8'(DRIVE_TORCH), "uv torch");
        @(posedge clk_sys);
        undervoltage_raw <= 1'b0;
        vin_recovered_raw <= 1'b1;
        cy(6);
        chk(8'(led_drive), 8'(DRIVE_TORCH), "uv hold");
        rd(FA, 8'h40);
        cy(4);
        chk(8'(led_drive), 8'(DRIVE_FLASH), "uv release");
        results();
    end
endmodule // flp_flag_ctrl_bench

`default_nettype wire

//--- flp_host_model.sv
// host side of the register port: single-byte reads and writes by strobe
// assumes the bench calls one access at a time, after reset release
`default_nettype none

module flp_host_model (
    // clock
    input wire logic clk_sys,
    // register port
    output logic [7:0] reg_addr,
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [7:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        reg_addr = 8'h00;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_wdata = 8'h00;
    end

    // one strobe cycle; idle address and data are scrambled so nothing stale lingers
    task automatic access(input logic [7:0] a, input logic [7:0] d, input logic wr);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr_en <= wr;
        reg_rd_en <= !wr;
        @(posedge clk_sys);
        reg_wr_en <= 1'b0;
        reg_rd_en <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
endmodule // flp_host_model

`default_nettype wire

//--- flp_map.svh
// register map, field positions, reset values and timing counts of the flash
// protection flag block; assumes a 10 MHz system clock
`ifndef FLP_MAP_SVH
`define FLP_MAP_SVH

// register offsets
`define FLP_ADDR_VIN_MON 8'h80
`define FLP_ADDR_FLAGS 8'hD0
`define FLP_ADDR_PROT_CFG 8'hF0

// reset values
`define FLP_VIN_MON_RST 8'hF0
`define FLP_FLAGS_RST 8'h40
`define FLP_PROT_CFG_RST 8'hF0
`define FLP_FLAGS_MASK 8'h7F

// fault_flags bits
`define FLP_FLAG_TIMEOUT 0
`define FLP_FLAG_OVERTEMP 1
`define FLP_FLAG_LED_FAIL 2
`define FLP_FLAG_TX_A 3
`define FLP_FLAG_TX_B 4
`define FLP_FLAG_THERM 5
`define FLP_FLAG_VIN 6

// protection_config bits
`define FLP_CFG_TXB_OFF 0
`define FLP_CFG_THERM_ACT 1
`define FLP_CFG_ALT_TORCH 2
`define FLP_CFG_UV_ACT 3

// input_monitor_control bits
`define FLP_VIN_EN 0
`define FLP_VIN_THR_LO 1
`define FLP_VIN_THR_HI 2

// enable bit pairs {hi, lo}
`define FLP_MODE_IND 2'h1
`define FLP_MODE_TORCH 2'h2
`define FLP_MODE_FLASH 2'h3

// timing
`define FLP_CLK_PERIOD_NS 100
`define FLP_THERM_DEGLITCH_NS 250000
`define FLP_SHORT_QUAL_NS 250000
`define FLP_OPEN_QUAL_NS 2000
`define FLP_CYCLES_MIN(ns) (((ns) + `FLP_CLK_PERIOD_NS - 1) / `FLP_CLK_PERIOD_NS)
`define FLP_THERM_CYC `FLP_CYCLES_MIN(`FLP_THERM_DEGLITCH_NS)
`define FLP_SHORT_CYC `FLP_CYCLES_MIN(`FLP_SHORT_QUAL_NS)
`define FLP_OPEN_CYC `FLP_CYCLES_MIN(`FLP_OPEN_QUAL_NS)

`endif

//--- flp_pkg.sv
// types shared by the flash protection flag block
// assumes nothing of its surroundings
`default_nettype none

package flp_pkg;
    // led drive level, gray along off -> torch -> flash
    typedef enum logic [1:0] {
        DRIVE_OFF = 2'h0,
        DRIVE_TORCH = 2'h1,
        DRIVE_FLASH = 2'h3
    } flp_drive_e;
endpackage

`default_nettype wire

//--- flp_qual.sv
// qualifier: output rises once the input has stayed high for COUNT cycles
// assumes a synchronous input; output falls the cycle after the input drops
`default_nettype none

module flp_qual #(
    parameter int unsigned COUNT = 20
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // level in, qualified level out
    input wire logic level_in,
    output logic qualified
);

    localparam int CW = $clog2(COUNT + 1);
    localparam logic [CW-1:0] CNT_MAX = CW'(COUNT);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic out_q;

    assign cnt_d = !level_in ? '0 : (cnt_q == CNT_MAX) ? cnt_q : cnt_q + CW'(1);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
            out_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            out_q <= (cnt_d == CNT_MAX);
        end
    end

    assign qualified = out_q;

endmodule // flp_qual

`default_nettype wire

//--- flp_sync.sv
// two-flop synchronisers for a vector of asynchronous comparator levels
// assumes each bit is an independent level
`default_nettype none

module flp_sync #(
    parameter int W = 6
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                meta_q[i] <= 1'b0;
                sync_q[i] <= 1'b0;
            end else begin
                meta_q[i] <= async_in[i];
                sync_q[i] <= meta_q[i];
            end
        end
    end

    assign sync_out = sync_q;

endmodule // flp_sync

`default_nettype wire
